// File: src/wkd_pkg.sv
// wake input detect: shared constants and types
// assumes a 50 MHz core clock derived from the internal oscillator
package wkd_pkg;
    localparam int unsigned CLK_MHZ        = 50;
    localparam int unsigned FLT_SHORT_US   = 16;
    localparam int unsigned FLT_LONG_US    = 64;
    // filter lengths in clock cycles (least times, exact multiples here)
    localparam int unsigned FLT_SHORT_CYC  = FLT_SHORT_US * CLK_MHZ;
    localparam int unsigned FLT_LONG_CYC   = FLT_LONG_US * CLK_MHZ;
    localparam int unsigned FLT_CNT_W      = 12;
    // filter select field codes
    localparam logic [1:0]  FLT_STATIC_16  = 2'h0;
    localparam logic [1:0]  FLT_STATIC_64  = 2'h1;
    localparam logic [1:0]  FLT_CYCLIC_A   = 2'h2;
    localparam logic [1:0]  FLT_CYCLIC_B   = 2'h3;
    // bias select field codes
    localparam logic [1:0]  BIAS_NONE      = 2'h0;
    localparam logic [1:0]  BIAS_DOWN      = 2'h1;
    localparam logic [1:0]  BIAS_UP        = 2'h2;
    localparam logic [1:0]  BIAS_AUTO      = 2'h3;
    // operating modes of the surrounding device
    localparam logic [1:0]  MODE_FULL_RUN  = 2'h0;
    localparam logic [1:0]  MODE_LP_RUN    = 2'h1;
    localparam logic [1:0]  MODE_SUPPLY_OFF = 2'h2;
    localparam logic [1:0]  MODE_FAULT_HOLD = 2'h3;
    localparam int unsigned NUM_WAKE       = 3;
    localparam int unsigned NUM_ALT        = 2;
endpackage

// File: src/wkd_chan.sv
// wake input detect: one input channel (sync, deglitch, edge event)
// assumes pin is asynchronous; window and mode come from the same clock
`timescale 1ns/1ps
module wkd_chan (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       pin,
    input  wire logic [1:0] filt_sel,
    input  wire logic       window,
    output logic            event_p,
    output logic            level
);
    typedef struct packed {
        logic                            s1;
        logic                            s2;
        logic                            cand;
        logic [wkd_pkg::FLT_CNT_W-1:0]   cnt;
        logic                            stable;
        logic                            ev;
    } wkd_chan_s;

    wkd_chan_s st_r;
    wkd_chan_s st_nxt;
    logic [wkd_pkg::FLT_CNT_W-1:0] limit;
    logic                          active;

    // filter length and gating; cyclic modes sense only inside the window
    always_comb begin
        if (filt_sel == wkd_pkg::FLT_STATIC_64) begin
            limit = wkd_pkg::FLT_CNT_W'(wkd_pkg::FLT_LONG_CYC - 1);
        end else begin
            limit = wkd_pkg::FLT_CNT_W'(wkd_pkg::FLT_SHORT_CYC - 1);
        end
        active = !filt_sel[1] || window;
    end

    // next-state: s1 feeds only s2; filter restarts on every crossing
    always_comb begin
        st_nxt    = st_r;
        st_nxt.ev = 1'b0;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        if (!active) begin
            st_nxt.cand = st_r.stable; // outside window: ignore pin
            st_nxt.cnt  = '0;
        end else if (st_r.s2 != st_r.cand) begin
            st_nxt.cand = st_r.s2; // crossing restarts interval
            st_nxt.cnt  = '0;
        end else if (st_r.cand != st_r.stable) begin
            if (st_r.cnt == limit) begin
                st_nxt.stable = st_r.cand; // held long enough
                st_nxt.ev     = 1'b1;       // either direction
                st_nxt.cnt    = '0;
            end else begin
                st_nxt.cnt = st_r.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign event_p = st_r.ev;
    assign level   = st_r.stable;

    // a recognised short-filter change must match the synchronised input two cycles before the event
    short_filter_a: assert property (@(posedge clock) disable iff (rst)
        (st_r.ev && filt_sel == wkd_pkg::FLT_STATIC_16 && $stable(filt_sel))
        |-> $past(st_r.s2, 2) == st_r.stable)
        else $error("event without steady input");
    cnt_restart_a: assert property (@(posedge clock) disable iff (rst)
        (active && st_r.s2 != st_r.cand) |=> st_r.cnt == '0)
        else $error("filter did not restart on crossing");
    window_gate_a: assert property (@(posedge clock) disable iff (rst)
        !active |=> !st_r.ev)
        else $error("event outside cyclic window");
endmodule

// File: src/wkd_top.sv
// wake input detect: three wake pins plus two alternate output pins
// assumes mode, config and timer windows are synchronous to clock;
// pins are asynchronous and are synchronised inside each channel
// limitation: pull enables only request the current sources; the pads
// and the timer on-windows live outside this block
`timescale 1ns/1ps
module wkd_top (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       wake_pin_one,
    input  wire logic       wake_pin_two,
    input  wire logic       wake_pin_three,
    input  wire logic [1:0] alternate_output_pins,
    input  wire logic       alt_pins_as_wake,
    input  wire logic [1:0] op_mode,
    input  wire logic       cyclic_timer_a,
    input  wire logic       cyclic_timer_b,
    input  wire logic [2:0] wake_enable_control,
    input  wire logic [5:0] detect_filter_select,
    input  wire logic [5:0] bias_source_select,
    input  wire logic [2:0] wake_source_clear,
    input  wire logic [1:0] alt_status_clear,
    output logic      [2:0] wake_source_status,
    output logic      [1:0] alt_pin_wake_status,
    output logic      [2:0] pin_level_status,
    output logic      [2:0] pull_up_en,
    output logic      [2:0] pull_down_en,
    output logic            wake_irq,
    output logic            wake_request
);
    typedef struct packed {
        logic [2:0] src;
        logic [1:0] alt;
        logic [2:0] lvl;
        logic [2:0] pu;
        logic [2:0] pd;
        logic       irq;
        logic       wake;
    } wkd_top_s;

    // state register and the per-channel results of the filtered paths
    wkd_top_s   st_r;
    wkd_top_s   st_nxt;
    logic [2:0] pins;
    logic [2:0] ev;
    logic [2:0] lv;
    logic [1:0] alt_ev;
    logic [1:0] alt_lv;
    logic [2:0] win;
    logic       run_mode;

    // run modes interrupt; the supply-off and fault-hold modes wake instead
    assign pins = {wake_pin_three, wake_pin_two, wake_pin_one};
    assign run_mode = (op_mode == wkd_pkg::MODE_FULL_RUN) ||
                      (op_mode == wkd_pkg::MODE_LP_RUN);

    // one independent path per wake pin; window picks the assigned timer
    genvar g;
    generate
        for (g = 0; g < wkd_pkg::NUM_WAKE; g++) begin : g_wake
            assign win[g] = detect_filter_select[2*g] ? cyclic_timer_b
                                                      : cyclic_timer_a;
            wkd_chan u_chan (
                .clock    (clock),
                .rst      (rst),
                .pin      (pins[g]),
                .filt_sel (detect_filter_select[2*g+1 -: 2]),
                .window   (win[g]),
                .event_p  (ev[g]),
                .level    (lv[g])
            );
        end
        for (g = 0; g < wkd_pkg::NUM_ALT; g++) begin : g_alt
            // alternate pins have no filter choice, so the code is fixed
            wkd_chan u_alt ( // fixed static 16 us
                .clock    (clock),
                .rst      (rst),
                .pin      (alternate_output_pins[g]),
                .filt_sel (wkd_pkg::FLT_STATIC_16),
                .window   (1'b1),
                .event_p  (alt_ev[g]),
                .level    (alt_lv[g])
            );
        end
    endgenerate

    // flags set over clear so an event in the clear cycle is kept
    always_comb begin
        logic [2:0] hit;
        logic [1:0] alt_hit;
        hit     = ev & wake_enable_control;
        alt_hit = alt_pins_as_wake ? alt_ev : 2'h0;
        st_nxt  = st_r;
        st_nxt.src = (st_r.src & ~wake_source_clear) | hit;
        st_nxt.alt = (st_r.alt & ~alt_status_clear) | alt_hit;
        // filtered level; cyclic channels hold their last window sample
        if (run_mode) begin
            st_nxt.lvl = lv;
        end
        // pulses last one cycle; software reads the sticky flags
        st_nxt.irq  = run_mode && ((|hit) || (|alt_hit));
        st_nxt.wake = !run_mode && ((|hit) || (|alt_hit));
        // bias sources; auto follows the filtered level
        for (int i = 0; i < 3; i++) begin
            case (bias_source_select[2*i+1 -: 2])
                wkd_pkg::BIAS_DOWN: begin
                    st_nxt.pu[i] = 1'b0;
                    st_nxt.pd[i] = 1'b1;
                end
                wkd_pkg::BIAS_UP: begin
                    st_nxt.pu[i] = 1'b1;
                    st_nxt.pd[i] = 1'b0;
                end
                wkd_pkg::BIAS_AUTO: begin
                    st_nxt.pu[i] = lv[i];
                    st_nxt.pd[i] = !lv[i];
                end
                default: begin
                    st_nxt.pu[i] = 1'b0;
                    st_nxt.pd[i] = 1'b0;
                end
            endcase
        end
    end

    // reset leaves every bias source off, input floating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs come straight from the state register, no glue
    assign wake_source_status  = st_r.src;
    assign alt_pin_wake_status = st_r.alt;
    assign pin_level_status    = st_r.lvl;
    assign pull_up_en          = st_r.pu;
    assign pull_down_en        = st_r.pd;
    assign wake_irq            = st_r.irq;
    assign wake_request        = st_r.wake;

    // flag, interrupt, wake, level and bias checks on the registered outputs
    src_sticky_a: assert property (@(posedge clock) disable iff (rst)
        (|(ev & wake_enable_control)) |=> |st_r.src)
        else $error("wake flag not set");
    en_gate_a: assert property (@(posedge clock) disable iff (rst)
        (ev[2] && !wake_enable_control[2] && !wake_source_status[2])
        |=> !wake_source_status[2])
        else $error("disabled pin set its flag");
    irq_mode_a: assert property (@(posedge clock) disable iff (rst)
        (run_mode && |(ev & wake_enable_control))
        |=> wake_irq && !wake_request)
        else $error("run-mode event did not raise interrupt");
    wake_mode_a: assert property (@(posedge clock) disable iff (rst)
        (!run_mode && |(ev & wake_enable_control))
        |=> wake_request && !wake_irq)
        else $error("sleep-mode event did not wake");
    lvl_track_a: assert property (@(posedge clock) disable iff (rst)
        run_mode |=> pin_level_status == $past(lv))
        else $error("level status not tracking");
    bias_auto_a: assert property (@(posedge clock) disable iff (rst)
        bias_source_select[5:4] == wkd_pkg::BIAS_AUTO
        |=> pull_up_en[2] == $past(lv[2])
            && pull_down_en[2] != pull_up_en[2])
        else $error("automatic bias wrong");
    alt_flag_a: assert property (@(posedge clock) disable iff (rst)
        (alt_pins_as_wake && alt_ev[0]) |=> alt_pin_wake_status[0])
        else $error("alternate pin flag not set");
    set_wins_a: assert property (@(posedge clock) disable iff (rst)
        (ev[2] && wake_enable_control[2] && wake_source_clear[2])
        |=> wake_source_status[2])
        else $error("clear beat a simultaneous event");
    // alternate events are dropped while the pins serve as outputs
    alt_gate_a: assert property (@(posedge clock) disable iff (rst)
        !alt_pins_as_wake
        |=> (alt_pin_wake_status & ~$past(alt_pin_wake_status)) == 2'h0)
        else $error("alternate flag set while not a wake input");
    alt_clear_a: assert property (@(posedge clock) disable iff (rst)
        (alt_status_clear[0] && !(alt_pins_as_wake && alt_ev[0]))
        |=> !alt_pin_wake_status[0])
        else $error("alternate flag did not clear");
    alt_irq_a: assert property (@(posedge clock) disable iff (rst)
        (run_mode && alt_pins_as_wake && |alt_ev) |=> wake_irq)
        else $error("alternate event raised no interrupt");
    // outside run modes the level status must hold its last value
    level_hold_a: assert property (@(posedge clock) disable iff (rst)
        !run_mode |=> $stable(pin_level_status))
        else $error("level status moved outside run modes");
    // no enabled event, no pulse: guards against stray interrupts
    quiet_pulse_a: assert property (@(posedge clock) disable iff (rst)
        (!(|(ev & wake_enable_control)) && !(alt_pins_as_wake && |alt_ev))
        |=> !wake_irq && !wake_request)
        else $error("pulse without an enabled event");
    bias_down_a: assert property (@(posedge clock) disable iff (rst)
        bias_source_select[3:2] == wkd_pkg::BIAS_DOWN
        |=> pull_down_en[1] && !pull_up_en[1])
        else $error("pull-down select not applied");
    bias_none_a: assert property (@(posedge clock) disable iff (rst)
        bias_source_select[1:0] == wkd_pkg::BIAS_NONE
        |=> !pull_up_en[0] && !pull_down_en[0])
        else $error("current source on with none selected");
endmodule

// File: tb/wkd_pins.sv
// wake input detect: model of the switches and sensors on the pins
// assumes the bench commands every level change through drive()
`timescale 1ns/1ps
module wkd_pins (
    output logic [2:0] wake_pins,
    output logic [1:0] alt_pins
);
    logic [4:0] lvl_r = 5'h00;

    // switches hold a driven level, so no floating pin reaches the design
    assign wake_pins = lvl_r[2:0];
    assign alt_pins  = lvl_r[4:3];

    // index 0..2 wake pins, 3..4 alternate pins; called off the clock edge
    task drive(input int idx, input logic v);
        lvl_r[idx] = v;
    endtask
endmodule

// File: tb/wake_input_detect_tb.sv
// wake input detect: self-checking bench, one task per scenario
// assumes filter lengths of 800 and 3200 cycles at a 20 ns clock
`timescale 1ns/1ps
module wake_input_detect_tb;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] op_mode = 2'h0;
    logic       cyc_a = 1'b0;
    logic       cyc_b = 1'b0;
    logic       alt_wake = 1'b0;
    logic [2:0] en = 3'h0;
    logic [5:0] flt = 6'h00;
    logic [5:0] bias = 6'h00;
    logic [2:0] src_clr = 3'h0;
    logic [1:0] alt_clr = 2'h0;
    logic [2:0] src, lvl, pu, pd, pins;
    logic [1:0] alt_st, alt_pins;
    logic       irq, wreq;
    int         err_total = 0;
    int         compares = 0;
    int         n_irq, n_req;

    wkd_pins pm (.wake_pins(pins), .alt_pins(alt_pins));
    wkd_top uut (.clock(clock), .rst(rst), .wake_pin_one(pins[0]),
        .wake_pin_two(pins[1]), .wake_pin_three(pins[2]),
        .alternate_output_pins(alt_pins), .alt_pins_as_wake(alt_wake),
        .op_mode(op_mode), .cyclic_timer_a(cyc_a), .cyclic_timer_b(cyc_b),
        .wake_enable_control(en), .detect_filter_select(flt),
        .bias_source_select(bias), .wake_source_clear(src_clr),
        .alt_status_clear(alt_clr), .wake_source_status(src),
        .alt_pin_wake_status(alt_st), .pin_level_status(lvl),
        .pull_up_en(pu), .pull_down_en(pd), .wake_irq(irq),
        .wake_request(wreq));

    // free-running 50 MHz clock
    initial begin
        forever #10 clock = ~clock;
    end

    task end_of_test();
        if (err_total == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // irq and wake request are one-cycle pulses, so sample every cycle
    task run(input int cyc);
        n_irq = 0;
        n_req = 0;
        repeat (cyc) begin
            @(negedge clock);
            n_irq += int'(irq === 1'b1);
            n_req += int'(wreq === 1'b1);
        end
    endtask

    task clr_src();
        src_clr = 3'h7;
        run(1);
        src_clr = 3'h0;
        run(1);
    endtask

    task t_static16();
        en = 3'h7;
        pm.drive(0, 1'b1);
        run(780);
        chk(8'(src), 8'h00);
        run(40);
        chk(8'(n_irq), 8'h01);
        chk(8'(src), 8'h01);
        chk(8'(lvl), 8'h01);
        clr_src();
    endtask

    // pulse shorter than the filter must vanish without trace
    task t_glitch();
        pm.drive(1, 1'b1);
        run(600);
        pm.drive(1, 1'b0);
        run(1000);
        chk(8'(src), 8'h00);
        chk(8'(n_irq), 8'h00);
    endtask

    task t_long_fall_sleep();
        flt = 6'h01;
        op_mode = 2'h2;
        pm.drive(0, 1'b0);
        run(3150);
        chk(8'(src), 8'h00);
        run(80);
        chk(8'(src), 8'h01);
        chk(8'(n_req), 8'h01);
        chk(8'(n_irq), 8'h00);
        op_mode = 2'h1;
        clr_src();
    endtask

    task t_disabled();
        en = 3'h3;
        pm.drive(2, 1'b1);
        run(840);
        chk(8'(src), 8'h00);
        chk(8'(n_irq), 8'h00);
        chk(8'(lvl), 8'h04);
        en = 3'h7;
    endtask

    // pin two on timer a, pin three on timer b, windows opened one at a time
    task t_cyclic();
        flt = 6'h39;
        pm.drive(1, 1'b1);
        pm.drive(2, 1'b0);
        run(1000);
        chk(8'(src), 8'h00);
        chk(8'(lvl), 8'h04);
        cyc_a = 1'b1;
        run(840);
        chk(8'(src), 8'h02);
        cyc_a = 1'b0;
        cyc_b = 1'b1;
        run(801);
        src_clr = 3'h4; // clear meets the event cycle: the set must win
        run(1);
        src_clr = 3'h0;
        run(38);
        chk(8'(src), 8'h06);
        chk(8'(lvl), 8'h02);
        cyc_b = 1'b0;
    endtask

    task t_bias();
        chk(8'({pu, pd}), 8'h00);
        bias = 6'h36; // pin one up, pin two down, pin three automatic
        run(3);
        chk(8'(pu), 8'h01);
        chk(8'(pd), 8'h06);
        pm.drive(2, 1'b1);
        run(840);
        chk(8'(pu), 8'h05);
        chk(8'(pd), 8'h02);
        pm.drive(2, 1'b0);
        run(840);
        chk(8'(pd), 8'h06);
    endtask

    task t_alt();
        pm.drive(4, 1'b1);
        run(840);
        chk(8'(alt_st), 8'h00);
        alt_wake = 1'b1;
        pm.drive(3, 1'b1);
        run(780);
        chk(8'(alt_st), 8'h00);
        run(40);
        chk(8'(alt_st), 8'h01);
        chk(8'(n_irq), 8'h01);
        alt_clr = 2'h3;
        run(1);
        alt_clr = 2'h0;
        run(1);
        chk(8'(alt_st), 8'h00);
    endtask

    // watchdog: the scenarios need about 12500 cycles
    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        run(4);
        t_bias();
        t_static16();
        t_glitch();
        t_long_fall_sleep();
        t_disabled();
        t_cyclic();
        t_alt();
        end_of_test();
    end
endmodule
